// *** inc/omf_pkg.sv ***
/*
 package for the operation-mode state machine: mode codes, command codes,
 fault cause width and reset values. assumes nothing of its surroundings.
*/
package omf_pkg;
    // operation modes, binary codes written out
    typedef enum logic [2:0]
    {
        OMF_INIT  = 3'h0,
        OMF_RUN   = 3'h1,
        OMF_HALT  = 3'h2,
        OMF_ERROR = 3'h3,
        OMF_HOLD  = 3'h4,
        OMF_RUNF  = 3'h5
    } omf_mode_t;

    // tool commands, valid with cmd_valid_i
    typedef enum logic [3:0]
    {
        OMF_CMD_NONE   = 4'h0,
        OMF_CMD_RUN    = 4'h1,
        OMF_CMD_HALT   = 4'h2,
        OMF_CMD_RUNF   = 4'h3,
        OMF_CMD_HOLD   = 4'h4,
        OMF_CMD_HOLDC  = 4'h5,
        OMF_CMD_ERST   = 4'h6,
        OMF_CMD_LOAD   = 4'h7,
        OMF_CMD_EDIT   = 4'h8,
        OMF_CMD_NVWR   = 4'h9,
        OMF_CMD_NVRD   = 4'ha,
        OMF_CMD_OUTSET = 4'hb
    } omf_cmd_t;

    localparam int OMF_CAUSE_W = 8;
    localparam logic [7:0] OMF_CAUSE_RST = 8'h00;
    // cycles spent in init before the switch level chooses the power-up mode
    localparam int OMF_INIT_CYC = 4;
endpackage

// *** verilog/omf_sync.sv ***
/*
 two flip-flop synchroniser for one level.
 assumes the input is asynchronous to mclk_i.
*/
`timescale 1ns/1ps
module omf_sync
    import omf_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta_ff; // first stage, read only by q_ff
    logic q_ff;

    // two stages, first read by nothing else
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_ff <= 1'b0;
            q_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end
    assign q_o = q_ff;
endmodule

// *** verilog/omf_outgate.sv ***
/*
 output stage: chooses what drives the external outputs per mode.
 assumes mode flags come from the same clock domain.
*/
`timescale 1ns/1ps
module omf_outgate
    import omf_pkg::*;
#(
    parameter int OUT_W = 16
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // mode selection
    input wire logic pass_prog_i,
    input wire logic keep_i,
    input wire logic force_set_i,
    // data
    input wire logic [OUT_W-1:0] prog_out_i,
    input wire logic [OUT_W-1:0] force_data_i,
    output logic [OUT_W-1:0] out_o
);
    logic [OUT_W-1:0] out_ff; // registered output image

    // off unless program drives, held, or tool writes in hold
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            out_ff <= '0;
        else if (pass_prog_i)
            out_ff <= prog_out_i;
        else if (keep_i)
        begin
            if (force_set_i)
                out_ff <= force_data_i;
        end
        else
            out_ff <= '0;
    end
    assign out_o = out_ff;
endmodule

// *** verilog/omf_mode_ctrl.sv ***
/*
 operation-mode state machine of a small programmable controller.
 picks run, halt, error, hold or forced run from the front switch,
 tool commands and the self-diagnosis fault; gates execution, outputs
 and programming or nonvolatile permissions.
 assumes mode switch is an asynchronous pin, everything else is on mclk_i;
 the tool presents one command per cmd_valid_i pulse.
*/
`timescale 1ns/1ps

// What this block does
// - exactly one of six modes active
// - run samples inputs, executes, drives outputs
// - halt stops program, outputs off
// - load only in halt; basic edits halt-only
// - extended variant also edits, writes in run
// - fault from any mode but init enters error, outputs off
// - error left by reset command or power cycle
// - hold samples, refreshes, keeps outputs, no execution
// - tool sets outputs while in hold
// - forced run ignores missing expansion hardware
// - run to halt by switch or command
// - halt to run by switch or command
// - forced-run command enters forced run from run or halt
// - hold command enters, cancel leaves hold
// - tool mode commands need switch at run
// - nv read halt only; extended write not error
module omf_mode_ctrl
    import omf_pkg::*;
#(
    parameter int OUT_W = 16,
    parameter int IN_W = 16,
    parameter bit EXTENDED = 1'b0
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // front switch pin, high at run position
    input wire logic sw_run_i,
    // tool command port
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_i,
    input wire logic [OUT_W-1:0] cmd_data_i,
    // self-diagnosis
    input wire logic fault_i,
    input wire logic [OMF_CAUSE_W-1:0] fault_cause_i,
    input wire logic hw_missing_i,
    // scan interface
    input wire logic [IN_W-1:0] ext_in_i,
    input wire logic [OUT_W-1:0] prog_out_i,
    // status and permissions
    output logic [2:0] mode_o,
    output logic exec_en_o,
    output logic in_sample_o,
    output logic [IN_W-1:0] in_image_o,
    output logic [OUT_W-1:0] out_o,
    output logic [OMF_CAUSE_W-1:0] err_cause_o,
    output logic cmd_ack_o,
    output logic cmd_nak_o,
    output logic load_go_o,
    output logic edit_go_o,
    output logic nvwr_go_o,
    output logic nvrd_go_o
);
    // elaboration checks: refuse widths the logic cannot serve
    if (OUT_W < 1 || IN_W < 1)
    begin
        $error("omf_mode_ctrl: widths must be positive");
    end
    // the settle counter is three bits wide and must reach its end
    if (OMF_INIT_CYC < 1 || OMF_INIT_CYC > 7)
    begin
        $error("omf_mode_ctrl: settle count must fit three bits");
    end

    omf_mode_t mode_ff; // current mode
    omf_mode_t nxt_mode;
    logic sw_run; // synchronised switch
    logic sw_run_d_ff; // previous switch level, for edges
    logic [2:0] init_cnt_ff; // settle counter at power-up
    logic [OMF_CAUSE_W-1:0] cause_ff;
    logic [IN_W-1:0] in_ff;
    logic ack_ff, nak_ff;
    logic load_ff, edit_ff, nvwr_ff, nvrd_ff;
    logic is_run, is_runf, is_hold, is_halt, is_err;
    logic mode_cmd; // command is a mode-change command
    logic mode_cmd_ok; // accepted mode-change command
    logic sw_to_run, sw_to_halt;
    logic halted_run; // run stopped for missing hardware
    logic grant; // permission for non-mode command
    logic outset; // hold output write

    omf_sync u_sync
    (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(sw_run_i),
        .q_o(sw_run)
    );

    // decodes of the single mode register
    assign is_run = (mode_ff == OMF_RUN);
    assign is_runf = (mode_ff == OMF_RUNF);
    assign is_hold = (mode_ff == OMF_HOLD);
    assign is_halt = (mode_ff == OMF_HALT);
    assign is_err = (mode_ff == OMF_ERROR);
    // switch moves, taken from the synced level only
    assign sw_to_run = sw_run && !sw_run_d_ff;
    assign sw_to_halt = !sw_run && sw_run_d_ff;
    // plain run stalls when expansion hardware is missing; forced run does not
    assign halted_run = is_run && hw_missing_i;

    // which commands count as mode changes
    always_comb
    begin
        unique case (omf_cmd_t'(cmd_i))
            OMF_CMD_RUN, OMF_CMD_HALT, OMF_CMD_RUNF,
            OMF_CMD_HOLD, OMF_CMD_HOLDC, OMF_CMD_ERST: mode_cmd = 1'b1;
            // the rest are programming, nonvolatile or output requests
            default: mode_cmd = 1'b0;
        endcase
    end
    // ignored with switch at halt
    assign mode_cmd_ok = cmd_valid_i && mode_cmd && sw_run;

    // permission for programming and nonvolatile commands
    always_comb
    begin
        // refused requests leave grant low and are answered with a nak
        grant = 1'b0;
        outset = 1'b0;
        if (cmd_valid_i && !mode_cmd)
        begin
            unique case (omf_cmd_t'(cmd_i))
                OMF_CMD_LOAD: grant = is_halt;
                OMF_CMD_EDIT: grant = is_halt || (EXTENDED && is_run);
                OMF_CMD_NVWR: grant = EXTENDED ? (!is_err && mode_ff != OMF_INIT) : is_halt;
                OMF_CMD_NVRD: grant = is_halt;
                OMF_CMD_OUTSET:
                begin
                    grant = is_hold;
                    outset = is_hold;
                end
                default: grant = 1'b0;
            endcase
        end
    end

    // next-mode logic; fault beats everything outside init
    always_comb
    begin
        nxt_mode = mode_ff;
        if (fault_i && mode_ff != OMF_INIT)
            nxt_mode = OMF_ERROR;
        else
        begin
            unique case (mode_ff)
                OMF_INIT:
                begin
                    // the level, not an edge, picks the first mode
                    if (init_cnt_ff == 3'(OMF_INIT_CYC))
                        nxt_mode = sw_run ? OMF_RUN : OMF_HALT;
                end
                OMF_RUN, OMF_RUNF:
                begin
                    // halt wins over any other mode command
                    if (sw_to_halt || (mode_cmd_ok && cmd_i == OMF_CMD_HALT))
                        nxt_mode = OMF_HALT;
                    else if (mode_cmd_ok && cmd_i == OMF_CMD_RUNF)
                        nxt_mode = OMF_RUNF;
                    else if (mode_cmd_ok && cmd_i == OMF_CMD_HOLD)
                        nxt_mode = OMF_HOLD;
                end
                OMF_HALT:
                begin
                    // switch edge to run or run command
                    if (sw_to_run || (mode_cmd_ok && cmd_i == OMF_CMD_RUN))
                        nxt_mode = OMF_RUN;
                    else if (mode_cmd_ok && cmd_i == OMF_CMD_RUNF)
                        nxt_mode = OMF_RUNF;
                end
                OMF_HOLD:
                begin
                    // switch to halt or halt command also leaves hold
                    if (sw_to_halt || (mode_cmd_ok && cmd_i == OMF_CMD_HALT))
                        nxt_mode = OMF_HALT;
                    else if (mode_cmd_ok && cmd_i == OMF_CMD_HOLDC)
                        nxt_mode = OMF_RUN;
                end
                OMF_ERROR:
                begin
                    // only the reset command; otherwise a power cycle
                    if (mode_cmd_ok && cmd_i == OMF_CMD_ERST)
                        nxt_mode = sw_run ? OMF_RUN : OMF_HALT;
                end
                default: nxt_mode = OMF_INIT;
            endcase
        end
    end

    // single mode register keeps exactly one mode active
    // illegal codes fall back to init through the next-mode default
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mode_ff <= OMF_INIT;
        else
            mode_ff <= nxt_mode;
    end

    // power-up settle counter and switch edge history
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            init_cnt_ff <= 3'h0;
            sw_run_d_ff <= 1'b0;
        end
        else
        begin
            if (mode_ff == OMF_INIT && init_cnt_ff != 3'(OMF_INIT_CYC))
                init_cnt_ff <= init_cnt_ff + 3'h1;
            // history tracks the synced level every cycle; in init the
            // level itself picks the mode, so a switch held at run gives no edge
            sw_run_d_ff <= sw_run;
        end
    end

    // fault cause kept for the tool until error reset
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cause_ff <= OMF_CAUSE_RST;
        else if (fault_i && !is_err && mode_ff != OMF_INIT)
            cause_ff <= fault_cause_i;
        // a fault seen in error keeps the first cause
        else if (is_err && nxt_mode != OMF_ERROR)
            cause_ff <= OMF_CAUSE_RST;
    end

    // input image: sampled in run, forced run and hold, not in halt or error
    // halt and error freeze the last image rather than clearing it
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            in_ff <= '0;
        else if (is_run || is_runf || is_hold)
            in_ff <= ext_in_i;
    end

    // command answers and one-cycle grants
    // ack and nak are exclusive, one cycle after the command
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_ff <= 1'b0;
            nak_ff <= 1'b0;
            load_ff <= 1'b0;
            edit_ff <= 1'b0;
            nvwr_ff <= 1'b0;
            nvrd_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= mode_cmd_ok || grant;
            nak_ff <= cmd_valid_i && !(mode_cmd_ok || grant);
            load_ff <= grant && cmd_i == OMF_CMD_LOAD;
            edit_ff <= grant && cmd_i == OMF_CMD_EDIT;
            nvwr_ff <= grant && cmd_i == OMF_CMD_NVWR;
            nvrd_ff <= grant && cmd_i == OMF_CMD_NVRD;
        end
    end

    // outputs follow program in forced run and in run with hardware present, held in hold, off otherwise
    // registered, so outputs drop one cycle after the mode changes
    omf_outgate #(.OUT_W(OUT_W)) u_out
    (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .pass_prog_i((is_run && !halted_run) || is_runf),
        .keep_i(is_hold),
        .force_set_i(outset),
        .prog_out_i(prog_out_i),
        .force_data_i(cmd_data_i),
        .out_o(out_o)
    );

    // status straight from registers or mode decodes, exec_en_o also gated by hw_missing_i
    assign mode_o = mode_ff;
    assign exec_en_o = (is_run && !halted_run) || is_runf;
    assign in_sample_o = is_run || is_runf || is_hold;
    assign in_image_o = in_ff;
    assign err_cause_o = cause_ff;
    assign cmd_ack_o = ack_ff;
    assign cmd_nak_o = nak_ff;
    assign load_go_o = load_ff;
    assign edit_go_o = edit_ff;
    assign nvwr_go_o = nvwr_ff;
    assign nvrd_go_o = nvrd_ff;
endmodule

// *** verification/omf_mode_props.sv ***
/*
 concurrent checks on the mode machine's ports.
 assumes a bind into omf_mode_ctrl, one clock domain.
*/
`timescale 1ns/1ps
module omf_mode_props
    import omf_pkg::*;
#(
    parameter int OUT_W = 16,
    parameter bit EXTENDED = 1'b0
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // stimulus side
    input wire logic sw_run_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_i,
    input wire logic [OUT_W-1:0] cmd_data_i,
    input wire logic fault_i,
    // design answers
    input wire logic [2:0] mode_o,
    input wire logic exec_en_o,
    input wire logic in_sample_o,
    input wire logic [OUT_W-1:0] out_o,
    input wire logic cmd_ack_o,
    input wire logic cmd_nak_o,
    input wire logic load_go_o,
    input wire logic edit_go_o,
    input wire logic nvrd_go_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // switch steady at run over the whole sync lag
    sequence s_sw_run;
        $past(sw_run_i, 1) && $past(sw_run_i, 2) && $past(sw_run_i, 3);
    endsequence
    // a command with no fault competing, since fault wins
    sequence s_cmd(logic [3:0] c);
        cmd_valid_i && cmd_i == c && !fault_i;
    endsequence
    chk_fault_err: assert property (fault_i && mode_o != OMF_INIT |=> mode_o == OMF_ERROR)
        else $error("fault did not enter error");
    chk_err_dark: assert property (mode_o == OMF_ERROR |-> !exec_en_o ##1 (mode_o != OMF_ERROR || out_o == '0))
        else $error("error mode still active");
    chk_err_stay: assert property (mode_o == OMF_ERROR && !(cmd_valid_i && cmd_i == OMF_CMD_ERST) |=> mode_o == OMF_ERROR)
        else $error("error left without reset");
    chk_halt_dark: assert property (mode_o == OMF_HALT |-> !exec_en_o && !in_sample_o ##1 (mode_o != OMF_HALT || out_o == '0))
        else $error("halt mode still active");
    chk_grant_halt: assert property (load_go_o || nvrd_go_o || (edit_go_o && !EXTENDED) |-> $past(mode_o) == OMF_HALT)
        else $error("grant outside halt");
    chk_ack_xor: assert property (cmd_valid_i |=> cmd_ack_o != cmd_nak_o)
        else $error("command not answered once");
    chk_hold_freeze: assert property (mode_o == OMF_HOLD && !cmd_valid_i ##1 mode_o == OMF_HOLD |-> $stable(out_o) && !exec_en_o && in_sample_o)
        else $error("hold outputs moved");
    chk_outset_drive: assert property (s_cmd(OMF_CMD_OUTSET) ##0 mode_o == OMF_HOLD |=> out_o == $past(cmd_data_i) && cmd_ack_o)
        else $error("hold output set not driven");
    chk_run_halt: assert property (mode_o == OMF_RUN ##0 s_cmd(OMF_CMD_HALT) ##0 s_sw_run |=> mode_o == OMF_HALT)
        else $error("halt command ignored");
    chk_halt_run: assert property (mode_o == OMF_HALT ##0 s_cmd(OMF_CMD_RUN) ##0 s_sw_run |=> mode_o == OMF_RUN)
        else $error("run command ignored");
    chk_runf_exec: assert property (mode_o == OMF_RUNF |-> exec_en_o && in_sample_o)
        else $error("forced run not executing");
    chk_runf_enter: assert property ((mode_o == OMF_RUN || mode_o == OMF_HALT) ##0 s_cmd(OMF_CMD_RUNF) ##0 s_sw_run |=> mode_o == OMF_RUNF)
        else $error("forced run command ignored");
endmodule

// *** verification/omf_tool_model.sv ***
/*
 model of the programming tool and the front mode switch.
 assumes the controller answers one cycle after each command.
*/
`timescale 1ns/1ps
module omf_tool_model
    import omf_pkg::*;
#(
    parameter int OUT_W = 16
)
(
    // clock
    input wire logic mclk_i,
    // controller answers
    input wire logic ack_i,
    input wire logic nak_i,
    // switch and command lines
    output logic sw_run_o,
    output logic cmd_valid_o,
    output logic [3:0] cmd_o,
    output logic [OUT_W-1:0] data_o
);
    // idle at halt position, no command
    initial
    begin
        sw_run_o = 1'b0;
        cmd_valid_o = 1'b0;
        cmd_o = 4'h0;
        data_o = '0;
    end
    // switch moved between edges, like a hand would
    task automatic set_sw(input logic v);
        @(negedge mclk_i);
        sw_run_o = v;
    endtask
    // one command pulse, answer read after it ends
    task automatic send(input logic [3:0] c, input logic [OUT_W-1:0] d, output logic [1:0] r);
        @(negedge mclk_i);
        cmd_valid_o = 1'b1;
        cmd_o = c;
        data_o = d; // output pattern for hold
        @(negedge mclk_i);
        cmd_valid_o = 1'b0; // one cycle per command
        // stale lines inverted so nothing lingers as valid
        cmd_o = ~c;
        data_o = ~d;
        r = {ack_i, nak_i};
    endtask
endmodule

// *** verification/tb.sv ***
/*
 self-checking bench for the mode machine, tool model on the command port.
 assumes package, design, checker and tool model compiled before it.
*/
`timescale 1ns/1ps
module tb
    import omf_pkg::*;
;
    logic mclk_i, nrst_i, sw_run_i, cmd_valid_i, fault_i, hw_missing_i;
    logic exec_en_o, in_sample_o, cmd_ack_o, cmd_nak_o;
    logic [3:0] cmd_i, go;
    logic [3:0] go_x; // grants of the extended variant
    logic [15:0] cmd_data_i, ext_in_i, prog_out_i, in_image_o, out_o;
    logic [7:0] fault_cause_i, err_cause_o;
    logic [2:0] mode_o;
    logic [1:0] r; // {ack, nak} of last command
    int fails, n_checks;
    // design under test, basic variant
    omf_mode_ctrl u_dut (.mclk_i, .nrst_i, .sw_run_i, .cmd_valid_i, .cmd_i, .cmd_data_i, .fault_i,
        .fault_cause_i, .hw_missing_i, .ext_in_i, .prog_out_i, .mode_o, .exec_en_o, .in_sample_o,
        .in_image_o, .out_o, .err_cause_o, .cmd_ack_o, .cmd_nak_o, .load_go_o(go[3]),
        .edit_go_o(go[2]), .nvwr_go_o(go[1]), .nvrd_go_o(go[0]));
    // extended variant on the same stimulus, only its grants compared
    omf_mode_ctrl #(.EXTENDED(1'b1)) u_dut_x (.mclk_i, .nrst_i, .sw_run_i, .cmd_valid_i, .cmd_i, .cmd_data_i,
        .fault_i, .fault_cause_i, .hw_missing_i, .ext_in_i, .prog_out_i, .mode_o(), .exec_en_o(),
        .in_sample_o(), .in_image_o(), .out_o(), .err_cause_o(), .cmd_ack_o(), .cmd_nak_o(),
        .load_go_o(go_x[3]), .edit_go_o(go_x[2]), .nvwr_go_o(go_x[1]), .nvrd_go_o(go_x[0]));
    omf_tool_model u_tool (.mclk_i, .ack_i(cmd_ack_o), .nak_i(cmd_nak_o), .sw_run_o(sw_run_i),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .data_o(cmd_data_i));
    // 20 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // power-up at halt position, then switch to run
    task automatic t_power();
        cyc(10);
        chk(mode_o, OMF_HALT);
        u_tool.set_sw(1'b1);
        cyc(4);
        chk(mode_o, OMF_RUN);
    endtask
    // run scans inputs and passes program results
    task automatic t_run();
        prog_out_i = 16'h1234;
        ext_in_i = 16'h00c3;
        cyc(3);
        chk(out_o, 16'h1234);
        chk(in_image_o, 16'h00c3);
        chk({exec_en_o, in_sample_o}, 2'h3);
    endtask
    // hold freezes outputs, tool overrides them
    task automatic t_hold();
        u_tool.send(OMF_CMD_HOLD, 16'h0, r);
        chk({r, mode_o}, {2'h2, OMF_HOLD});
        prog_out_i = 16'habcd;
        cyc(3);
        chk(out_o, 16'h1234);
        u_tool.send(OMF_CMD_OUTSET, 16'h0f0f, r);
        chk(out_o, 16'h0f0f);
        u_tool.send(OMF_CMD_HOLDC, 16'h0, r);
        chk(mode_o, OMF_RUN);
    endtask
    // load, edit, nv write, nv read: granted in halt; refused in run, except edit and nv write in the extended variant
    task automatic t_perm();
        for (int h = 0; h < 2; h++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                u_tool.send(4'(4'h7 + i), 16'h0, r);
                chk({r, go}, h ? {2'h2, 4'h8 >> i} : {2'h1, 4'h0});
                chk(go_x, (h || i == 1 || i == 2) ? 4'(4'h8 >> i) : 4'h0);
            end
            u_tool.send(OMF_CMD_HALT, 16'h0, r);
        end
        chk(mode_o, OMF_HALT);
        chk(out_o, 16'h0);
    endtask
    // missing hardware stops run but not forced run
    task automatic t_runf();
        u_tool.send(OMF_CMD_RUN, 16'h0, r);
        chk(mode_o, OMF_RUN);
        hw_missing_i = 1'b1;
        cyc(2);
        chk(exec_en_o, 1'b0);
        chk(out_o, 16'h0);
        u_tool.send(OMF_CMD_RUNF, 16'h0, r);
        cyc(1);
        chk({mode_o, exec_en_o}, {OMF_RUNF, 1'b1});
        chk(out_o, 16'habcd);
        hw_missing_i = 1'b0;
    endtask
    // switch at halt wins and locks out tool mode commands
    task automatic t_switch();
        u_tool.set_sw(1'b0);
        cyc(4);
        chk(mode_o, OMF_HALT);
        u_tool.send(OMF_CMD_RUN, 16'h0, r);
        chk({r, mode_o}, {2'h1, OMF_HALT});
        u_tool.set_sw(1'b1);
        cyc(4);
        chk(mode_o, OMF_RUN);
    endtask
    // fault shuts down until error reset
    task automatic t_fault();
        @(negedge mclk_i);
        fault_i = 1'b1;
        fault_cause_i = 8'h5a;
        @(negedge mclk_i);
        fault_i = 1'b0;
        fault_cause_i = 8'h00;
        chk({mode_o, err_cause_o}, {OMF_ERROR, 8'h5a});
        u_tool.send(OMF_CMD_RUN, 16'h0, r);
        chk({mode_o, out_o[7:0]}, {OMF_ERROR, 8'h00});
        u_tool.send(OMF_CMD_NVWR, 16'h0, r);
        chk({r, go_x}, {2'h1, 4'h0});
        u_tool.send(OMF_CMD_ERST, 16'h0, r);
        cyc(1);
        chk({mode_o, err_cause_o}, {OMF_RUN, 8'h00});
    endtask
    // power cycle leaves error; switch at run picks run at power-up
    task automatic t_cycle();
        @(negedge mclk_i);
        fault_i = 1'b1;
        fault_cause_i = 8'h3c;
        @(negedge mclk_i);
        fault_i = 1'b0;
        fault_cause_i = 8'h00;
        chk({mode_o, err_cause_o}, {OMF_ERROR, 8'h3c});
        nrst_i = 1'b0;
        cyc(6);
        chk(mode_o, OMF_INIT);
        chk(out_o, 16'h0);
        nrst_i = 1'b1;
        cyc(10);
        chk({mode_o, err_cause_o}, {OMF_RUN, 8'h00});
    endtask
    // main sequence, reset held six cycles
    initial
    begin
        nrst_i = 1'b0;
        fault_i = 1'b0;
        fault_cause_i = 8'h00;
        hw_missing_i = 1'b0;
        ext_in_i = 16'h0;
        prog_out_i = 16'h0;
        fails = 0;
        n_checks = 0;
        cyc(6);
        nrst_i = 1'b1;
        t_power();
        t_run();
        t_hold();
        t_perm();
        t_runf();
        t_switch();
        t_fault();
        t_cycle();
        summarize();
    end
    // watchdog, far beyond the hundred or so cycles expected
    initial
    begin
        #(50 * 3000);
        fails++;
        summarize();
    end
endmodule
bind omf_mode_ctrl omf_mode_props #(.OUT_W(OUT_W), .EXTENDED(EXTENDED)) u_props (.mclk_i, .nrst_i,
    .sw_run_i, .cmd_valid_i, .cmd_i, .cmd_data_i, .fault_i, .mode_o, .exec_en_o, .in_sample_o,
    .out_o, .cmd_ack_o, .cmd_nak_o, .load_go_o, .edit_go_o, .nvrd_go_o);
